/* File: core/lldpi_ctrl_end.sv */
// memory controller end: makes cmd_clk, issues commands, moves data
// assumes i_clk at twice the link rate; one request in flight at a time
`timescale 1ns/10ps
module lldpi_ctrl_end
    import lldpi_pkg::*;
(
    lldpi_link_if.ctrl               link,
    input  wire logic                i_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_req_valid,
    input  wire lldpi_cmd_e          i_req_cmd,
    input  wire logic [BANK_W-1:0]   i_req_bank,
    input  wire logic [ADDR_W-1:0]   i_req_addr,
    input  wire logic [2*DQ_W-1:0]   i_req_wdata,
    input  wire logic [1:0]          i_req_wmask,
    output logic                     o_req_ready,
    output logic                     o_rd_valid,
    output logic [2*DQ_W-1:0]        o_rd_data
);

    typedef enum {ST_IDLE, ST_CMD, ST_CMD2, ST_W0, ST_W1, ST_RWAIT} lldpi_st_e;

    lldpi_st_e         state_q;
    lldpi_st_e         state_d;
    logic              div_q;
    logic              div_n_q;
    logic              ready_q;
    logic              take;
    logic              rd_evt;
    lldpi_cmd_e        cmd_q;
    logic              cs_n_q;
    logic [1:0]        pins_q;
    logic [ADDR_W-1:0] addr_q;
    logic [BANK_W-1:0] bank_q;
    logic [2*DQ_W-1:0] wdata_q;
    logic [1:0]        wmask_q;
    logic [DQ_W-1:0]   dq_q;
    logic              dq_oe_q;
    logic              mask_q;
    logic [DQ_W-1:0]   lo_q;
    logic [DQ_W-1:0]   hi_q;
    logic              cap_tg_q;
    logic              seen_q;
    logic              rd_valid_q;
    logic [2*DQ_W-1:0] rd_data_q;

    assign take   = i_req_valid && ready_q;
    assign rd_evt = cap_tg_q != seen_q;

    // sequencing of one command and its data
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (take) state_d = ST_CMD;
            ST_CMD:   state_d = ST_CMD2;
            ST_CMD2:  state_d = (cmd_q == LLDPI_WRITE) ? ST_W0 :
                                (cmd_q == LLDPI_READ) ? ST_RWAIT : ST_IDLE;
            ST_W0:    state_d = ST_W1;
            ST_W1:    state_d = ST_IDLE;
            ST_RWAIT: if (rd_evt) state_d = ST_IDLE;
        endcase
    end

    // divider and state; ready only ahead of a falling cmd_clk edge
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_q   <= 1'b0;
            div_n_q <= 1'b1;
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
        end else begin
            div_q   <= ~div_q;
            div_n_q <= div_q;
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE) && !div_q;
        end
    end

    // command pins change only as cmd_clk falls; select low for one cmd_clk cycle, two i_clk cycles
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_n_q  <= 1'b1;
            pins_q  <= lldpi_encode(LLDPI_READ);
            cmd_q   <= LLDPI_READ;
            addr_q  <= '0;
            bank_q  <= '0;
            wdata_q <= '0;
            wmask_q <= '0;
        end else if (take) begin
            cs_n_q  <= 1'b0;                                   // RL2
            pins_q  <= lldpi_encode(i_req_cmd);
            cmd_q   <= i_req_cmd;
            addr_q  <= i_req_addr;
            bank_q  <= i_req_bank;
            wdata_q <= i_req_wdata;
            wmask_q <= i_req_wmask;
        end else if (state_q == ST_CMD2) begin
            cs_n_q  <= 1'b1;
        end
    end

    // write beats launched mid phase so each strobe edge sees stable data
    always_ff @(negedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dq_q    <= '0;
            dq_oe_q <= 1'b0;
            mask_q  <= 1'b0;
        end else if (state_q == ST_W0) begin
            dq_q    <= wdata_q[DQ_W-1:0];                      // RL11 RL15
            dq_oe_q <= 1'b1;
            mask_q  <= wmask_q[0];                             // RL17
        end else if (state_q == ST_W1) begin
            dq_q    <= wdata_q[2*DQ_W-1:DQ_W];                 // RL11 RL15
            dq_oe_q <= 1'b1;
            mask_q  <= wmask_q[1];                             // RL17
        end else begin
            dq_oe_q <= 1'b0;
            mask_q  <= 1'b0;
        end
    end

    // read beats sampled mid phase; cmd_clk level tells which beat
    always_ff @(negedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lo_q     <= '0;
            hi_q     <= '0;
            cap_tg_q <= 1'b0;
        end else if (link.rd_valid) begin
            if (div_q) begin
                lo_q <= link.dq;
            end else begin
                hi_q     <= link.dq;
                cap_tg_q <= ~cap_tg_q;
            end
        end
    end

    // completed burst handed to the user as a one cycle pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen_q     <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end else begin
            seen_q     <= cap_tg_q;
            rd_valid_q <= rd_evt;
            if (rd_evt) begin
                rd_data_q <= {hi_q, lo_q};
            end
        end
    end

    assign o_req_ready      = ready_q;
    assign o_rd_valid       = rd_valid_q;
    assign o_rd_data        = rd_data_q;
    assign link.cmd_clk     = div_q;
    assign link.cmd_clk_n   = div_n_q;
    assign link.wr_strobe   = {N_GRP{div_q}};
    assign link.wr_strobe_n = {N_GRP{div_n_q}};
    assign link.cs_n        = cs_n_q;
    assign link.we_n        = pins_q[1];
    assign link.ref_n       = pins_q[0];
    assign link.addr_in     = addr_q;
    assign link.bank_sel    = bank_q;
    assign link.host_dq_o   = dq_q;
    assign link.host_dq_oe  = dq_oe_q;
    assign link.wr_mask     = mask_q;

endmodule

/* File: core/lldpi_ddr_out.sv */
// double data rate output stage with its own edge-aligned strobe
// assumes a free running clock; the strobe follows it glitch free
`timescale 1ns/10ps
module lldpi_ddr_out #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_rise,
    input  wire logic [W-1:0] i_fall,
    output logic      [W-1:0] o_pin,
    output logic              o_strobe
);
    logic         tg_p_q;
    logic         tg_n_q;
    logic [W-1:0] rise_q;
    logic [W-1:0] fall_q;

    // rising edge beat and strobe toggle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tg_p_q <= 1'b0;
            rise_q <= '0;
        end else begin
            tg_p_q <= ~tg_p_q;
            rise_q <= i_rise;
        end
    end

    // falling edge beat; copying the toggle keeps the strobe in phase
    always_ff @(negedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tg_n_q <= 1'b0;
            fall_q <= '0;
        end else begin
            tg_n_q <= tg_p_q;
            fall_q <= i_fall;
        end
    end

    // strobe high after a rising edge, low after a falling one
    assign o_strobe = tg_p_q ^ tg_n_q;
    assign o_pin    = o_strobe ? rise_q : fall_q;

endmodule

/* File: core/lldpi_dram_end.sv */
// dram end of the pin link: command decode, write capture, read return
// assumes cmd_clk runs free and the write strobes are in phase with it
//
// Summary of operation
// RL1: address and control taken on cmd_clk rise
// RL2: commands only while select low
// RL3: select high ignores commands, pipelines keep going
// RL4: write and refresh pins decode the command
// RL5: address pins give row and column together
// RL6: config load stores address pins as settings
// RL7: expansion address bits never affect operation
// RL8: bank select picks the internal bank
// RL9: data bus is 9, 18 or 36 bits
// RL10: read beats on both read strobe edges
// RL11: write beats sampled on both write strobe edges
// RL12: read strobes run free, aligned with data
// RL13: x36 read pair 0 low half, pair 1 high
// RL14: x18 splits pairs at bit 9; x9 one pair
// RL15: x36 write pair per half; narrower use one
// RL16: masked write beat leaves stored data unchanged
// RL17: mask sampled both edges of write pair 1
// RL18: read valid marks data, strobe aligned
// RL19: read valid only during read burst beats
`timescale 1ns/10ps
module lldpi_dram_end
    import lldpi_pkg::*;
(
    lldpi_link_if.dram         link,
    input  wire logic          i_reset_n,
    output logic [ADDR_W-1:0]  o_cfg,
    output logic               o_refresh
);

    logic                take;
    lldpi_cmd_e          cmd;
    logic [IDX_W-1:0]    idx_d;

    logic [ADDR_W-1:0]   cfg_q;
    logic                refresh_q;
    logic [RL_W-1:0]     lat;

    logic                wr_act_q;
    logic                wr_act2_q;
    logic [IDX_W-1:0]    wr_idx_q;
    logic [IDX_W-1:0]    wr_idx2_q;
    logic [DQ_W-1:0]     wr_beat0;
    logic [DQ_W-1:0]     wr_beat1;
    logic                wr_m0_q;
    logic                wr_m1_q;

    logic [DQ_W-1:0]     mem_lo [MEM_DEPTH];
    logic [DQ_W-1:0]     mem_hi [MEM_DEPTH];

    logic [RL_DEPTH-1:0] rd_vld_q;
    logic [IDX_W-1:0]    rd_idx_q [RL_DEPTH];
    logic                out_vld_q;
    logic [IDX_W-1:0]    out_idx_q;
    logic [DQ_W:0]       rise_in;
    logic [DQ_W:0]       fall_in;
    logic [DQ_W:0]       pin_out;
    logic                rd_strb;

    // pin decode, sampled by the cmd_clk rise processes below
    assign take  = ~link.cs_n;                                 // RL2
    assign cmd   = lldpi_decode(link.we_n, link.ref_n);        // RL4
    assign idx_d = lldpi_index(link.bank_sel, link.addr_in);   // RL5 RL7 RL8

    // configuration register and refresh marker
    always_ff @(posedge link.cmd_clk or negedge i_reset_n) begin // RL1
        if (!i_reset_n) begin
            cfg_q     <= CFG_RESET;
            refresh_q <= 1'b0;
        end else begin
            if (take && cmd == LLDPI_CFG) begin                // RL3
                cfg_q <= link.addr_in;                         // RL6
            end
            refresh_q <= take && (cmd == LLDPI_REFRESH);
        end
    end

    assign o_cfg     = cfg_q;
    assign o_refresh = refresh_q;
    assign lat       = cfg_q[CFG_RL_LSB +: RL_W];

    // write command pipeline: data follows one cmd_clk cycle later
    always_ff @(posedge link.cmd_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_act_q  <= 1'b0;
            wr_act2_q <= 1'b0;
        end else begin
            wr_act_q  <= take && (cmd == LLDPI_WRITE);         // RL2 RL4
            wr_act2_q <= wr_act_q;
        end
    end

    // write addresses carried alongside the pipeline
    always_ff @(posedge link.cmd_clk) begin
        wr_idx_q  <= idx_d;                                    // RL8
        wr_idx2_q <= wr_idx_q;
    end

    // per group data capture on each edge of its own write strobe
    for (genvar g = 0; g < N_GRP; g++) begin : g_wcap
        logic [GRP_W-1:0] b0_q;
        logic [GRP_W-1:0] b1_q;

        // rising strobe beat
        always_ff @(posedge link.wr_strobe[g]) begin
            b0_q <= link.dq[g*GRP_W +: GRP_W];                 // RL11 RL15
        end

        // falling strobe beat
        always_ff @(negedge link.wr_strobe[g]) begin
            b1_q <= link.dq[g*GRP_W +: GRP_W];                 // RL11 RL15
        end

        assign wr_beat0[g*GRP_W +: GRP_W] = b0_q;
        assign wr_beat1[g*GRP_W +: GRP_W] = b1_q;
    end

    // mask rides with the beats on the upper write pair
    always_ff @(posedge link.wr_strobe[MASK_GRP]) begin
        wr_m0_q <= link.wr_mask;                               // RL17
    end

    // mask for the second beat
    always_ff @(negedge link.wr_strobe[MASK_GRP]) begin
        wr_m1_q <= link.wr_mask;                               // RL17
    end

    // first beat stored half a cycle after its capture
    always_ff @(negedge link.cmd_clk) begin
        if (wr_act2_q && !wr_m0_q) begin                       // RL16
            mem_lo[wr_idx2_q] <= wr_beat0;
        end
    end

    // second beat stored on the following rise
    always_ff @(posedge link.cmd_clk) begin
        if (wr_act2_q && !wr_m1_q) begin                       // RL16
            mem_hi[wr_idx2_q] <= wr_beat1;
        end
    end

    // read latency pipeline keeps moving while select is high
    always_ff @(posedge link.cmd_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_vld_q  <= '0;
            out_vld_q <= 1'b0;
        end else begin
            rd_vld_q  <= {rd_vld_q[RL_DEPTH-2:0],
                          take && (cmd == LLDPI_READ)};        // RL3 RL4
            out_vld_q <= rd_vld_q[lat];
        end
    end

    // read addresses shift with their valid bits
    always_ff @(posedge link.cmd_clk) begin
        rd_idx_q[0] <= idx_d;                                  // RL5 RL8
        for (int i = 1; i < RL_DEPTH; i++) begin
            rd_idx_q[i] <= rd_idx_q[i-1];
        end
        out_idx_q <= rd_idx_q[lat];
    end

    // burst beats with their valid flag; idle beats carry no valid
    assign rise_in = {rd_vld_q[lat], mem_lo[rd_idx_q[lat]]};   // RL19
    assign fall_in = {out_vld_q, mem_hi[out_idx_q]};           // RL19

    // one ddr stage for data and valid so both share the strobe edges
    lldpi_ddr_out #(
        .W (DQ_W + 1)
    ) u_rd_out (
        .i_clk     (link.cmd_clk),
        .i_reset_n (i_reset_n),
        .i_rise    (rise_in),
        .i_fall    (fall_in),
        .o_pin     (pin_out),
        .o_strobe  (rd_strb)
    );

    // read pins; both pairs share one edge source so groups stay aligned
    assign link.dev_dq_o    = pin_out[DQ_W-1:0];               // RL9 RL10
    assign link.rd_valid    = pin_out[DQ_W];                   // RL18 RL19
    assign link.dev_dq_oe   = pin_out[DQ_W];
    assign link.rd_strobe   = {N_GRP{rd_strb}};                // RL12 RL13 RL14
    assign link.rd_strobe_n = {N_GRP{~rd_strb}};               // RL12

endmodule

/* File: core/lldpi_link_if.sv */
// pin bundle between memory controller end and dram end
// the shared data bus level is resolved here from both output enables
`timescale 1ns/10ps
interface lldpi_link_if;
    import lldpi_pkg::*;

    logic                cmd_clk;
    logic                cmd_clk_n;
    logic                cs_n;
    logic                we_n;
    logic                ref_n;
    logic [ADDR_W-1:0]   addr_in;
    logic [BANK_W-1:0]   bank_sel;
    logic [N_GRP-1:0]    wr_strobe;
    logic [N_GRP-1:0]    wr_strobe_n;
    logic                wr_mask;
    logic [DQ_W-1:0]     host_dq_o;
    logic                host_dq_oe;
    logic [DQ_W-1:0]     dev_dq_o;
    logic                dev_dq_oe;
    logic [DQ_W-1:0]     dq;
    logic [N_GRP-1:0]    rd_strobe;
    logic [N_GRP-1:0]    rd_strobe_n;
    logic                rd_valid;

    // bus level; an undriven bus reads zero
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);

    modport ctrl (
        output cmd_clk, cmd_clk_n, cs_n, we_n, ref_n, addr_in, bank_sel,
        output wr_strobe, wr_strobe_n, wr_mask, host_dq_o, host_dq_oe,
        input  dq, rd_strobe, rd_strobe_n, rd_valid
    );

    modport dram (
        input  cmd_clk, cmd_clk_n, cs_n, we_n, ref_n, addr_in, bank_sel,
        input  wr_strobe, wr_strobe_n, wr_mask, dq,
        output dev_dq_o, dev_dq_oe, rd_strobe, rd_strobe_n, rd_valid
    );

endinterface

/* File: core/lldpi_pkg.sv */
// shared constants, command type and helper functions for the dram pin link
// assumes the x36 organisation and a small behavioural memory window
package lldpi_pkg;

    localparam int DQ_W      = 36;           // data bus width
    localparam int GRP_W     = 18;           // data bits per strobe group
    localparam int N_GRP     = 2;            // strobe pairs
    localparam int MASK_GRP  = 1;            // write pair that samples the mask
    localparam int ADDR_W    = 22;           // address pins
    localparam int EXP_LSB   = 20;           // first expansion address bit
    localparam int BANK_W    = 3;            // bank select pins
    localparam int MEM_AW    = 6;            // address bits kept in the model
    localparam int IDX_W     = BANK_W + MEM_AW;
    localparam int MEM_DEPTH = 1 << IDX_W;
    localparam int RL_W      = 3;            // read latency field width
    localparam int RL_DEPTH  = 1 << RL_W;
    localparam int CFG_RL_LSB = 0;           // read latency field position

    localparam logic [ADDR_W-1:0] CFG_RESET = 22'h00_0000;
    localparam logic [ADDR_W-1:0] EXP_MASK  = 22'h0F_FFFF;

    typedef enum logic [1:0] {
        LLDPI_READ,
        LLDPI_WRITE,
        LLDPI_REFRESH,
        LLDPI_CFG
    } lldpi_cmd_e;

    // command from the write and refresh pins
    function automatic lldpi_cmd_e lldpi_decode(input logic we_n, input logic ref_n);
        lldpi_cmd_e c;
        unique case ({we_n, ref_n})
            2'h3: c = LLDPI_READ;
            2'h1: c = LLDPI_WRITE;
            2'h2: c = LLDPI_REFRESH;
            2'h0: c = LLDPI_CFG;
        endcase
        return c;
    endfunction

    // pin levels {we_n, ref_n} for a command
    function automatic logic [1:0] lldpi_encode(input lldpi_cmd_e c);
        logic [1:0] p;
        unique case (c)
            LLDPI_READ:    p = 2'h3;
            LLDPI_WRITE:   p = 2'h1;
            LLDPI_REFRESH: p = 2'h2;
            LLDPI_CFG:     p = 2'h0;
        endcase
        return p;
    endfunction

    // memory index; expansion address bits never reach it
    function automatic logic [IDX_W-1:0] lldpi_index(input logic [BANK_W-1:0] b,
                                                     input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] e;
        e = a & EXP_MASK;
        return {b, e[MEM_AW-1:0]};
    endfunction

endpackage

/* File: verif/lldpi_assertions.sv */
// checker for the dram pin link, watching the interface signals only
// assumes cmd_clk is i_clk divided by two and one request in flight
`timescale 1ns/10ps
module lldpi_assertions
    import lldpi_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              cmd_clk,
    input  wire logic              cmd_clk_n,
    input  wire logic              cs_n,
    input  wire logic              we_n,
    input  wire logic              ref_n,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [N_GRP-1:0]  wr_strobe,
    input  wire logic [N_GRP-1:0]  wr_strobe_n,
    input  wire logic              host_dq_oe,
    input  wire logic              dev_dq_oe,
    input  wire logic [N_GRP-1:0]  rd_strobe,
    input  wire logic [N_GRP-1:0]  rd_strobe_n,
    input  wire logic              rd_valid
);
    logic       cmd_edge;
    logic [2:0] lat_q;
    logic [4:0] wait_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // cmd_clk rises at this edge with select low
    assign cmd_edge = !cs_n && !cmd_clk;

    // read latency as last loaded over the link
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lat_q <= 3'h0;
        end else if (cmd_edge && {we_n, ref_n} == 2'h0) begin
            lat_q <= addr_in[2:0];
        end
    end

    // countdown to the first read valid sample
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_q <= 5'h00;
        end else if (cmd_edge && {we_n, ref_n} == 2'h3) begin
            wait_q <= 5'(2 * lat_q + 3);
        end else if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
        end
    end

    property p_clk_pair; cmd_clk_n == ~cmd_clk; endproperty
    a_clk_pair: assert property (p_clk_pair)
        else $error("command clock pair not complementary");
    property p_rd_strb; rd_strobe == {N_GRP{cmd_clk}} && rd_strobe_n == ~rd_strobe; endproperty
    a_rd_strb: assert property (p_rd_strb)
        else $error("read strobes not free running with cmd_clk");
    property p_wr_strb; wr_strobe_n == ~wr_strobe && wr_strobe[0] == wr_strobe[1]; endproperty
    a_wr_strb: assert property (p_wr_strb)
        else $error("write strobe pairs misaligned");
    property p_oe_valid; dev_dq_oe == rd_valid && (!rd_valid || wait_q < 5'h02); endproperty
    a_oe_valid: assert property (p_oe_valid)
        else $error("device drives bus outside read beats");
    property p_no_clash; !(host_dq_oe && dev_dq_oe); endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data bus");
    property p_rd_beats;
        $rose(rd_valid) |-> rd_strobe[0] ##1 (rd_valid && !rd_strobe[0]) ##1 !rd_valid;
    endproperty
    a_rd_beats: assert property (p_rd_beats)
        else $error("read valid not two beats long");
    property p_rd_when; $rose(rd_valid) |-> wait_q == 5'h01; endproperty
    a_rd_when: assert property (p_rd_when)
        else $error("read data without read command or at wrong latency");
    property p_rd_due; wait_q == 5'h01 |-> rd_valid; endproperty
    a_rd_due: assert property (p_rd_due)
        else $error("read data missing at configured latency");
    property p_valid_edge; $changed(rd_valid) |-> rd_strobe[0]; endproperty
    a_valid_edge: assert property (p_valid_edge)
        else $error("read valid moves off the strobe rise");
    property p_wr_beats;
        cmd_edge && {we_n, ref_n} == 2'h1 |-> ##2 host_dq_oe [*2] ##1 !host_dq_oe;
    endproperty
    a_wr_beats: assert property (p_wr_beats)
        else $error("write beats not on both write strobe edges");

    // main command kinds seen on the link
    c_read: cover property (cmd_edge && {we_n, ref_n} == 2'h3);
    c_write: cover property (cmd_edge && {we_n, ref_n} == 2'h1);
    c_refresh: cover property (cmd_edge && {we_n, ref_n} == 2'h2);
    c_cfg: cover property (cmd_edge && {we_n, ref_n} == 2'h0);
endmodule

/* File: verif/tb.sv */
// testbench joining controller end and dram end over the pin link
// assumes both ends share one reset and i_clk feeds the controller end
`timescale 1ns/10ps
module tb;
    import lldpi_pkg::*;

    logic              i_clk;
    logic              i_reset_n;
    logic              i_req_valid;
    lldpi_cmd_e        i_req_cmd;
    logic [BANK_W-1:0] i_req_bank;
    logic [ADDR_W-1:0] i_req_addr;
    logic [2*DQ_W-1:0] i_req_wdata;
    logic [1:0]        i_req_wmask;
    logic              o_req_ready;
    logic              o_rd_valid;
    logic [2*DQ_W-1:0] o_rd_data;
    logic [ADDR_W-1:0] o_cfg;
    logic              o_refresh;
    logic [2*DQ_W-1:0] w;
    logic [2*DQ_W-1:0] v;
    logic [2*DQ_W-1:0] u;
    logic [ADDR_W-1:0] cfgv;
    int                num_errors;
    int                tests_run;
    int                cycles;
    int                last_wait;
    int                lat0;
    int                n;

    lldpi_link_if lldpi_link_if_inst ();

    lldpi_ctrl_end lldpi_ctrl_end_inst (
        .link        (lldpi_link_if_inst),
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_req_valid (i_req_valid),
        .i_req_cmd   (i_req_cmd),
        .i_req_bank  (i_req_bank),
        .i_req_addr  (i_req_addr),
        .i_req_wdata (i_req_wdata),
        .i_req_wmask (i_req_wmask),
        .o_req_ready (o_req_ready),
        .o_rd_valid  (o_rd_valid),
        .o_rd_data   (o_rd_data)
    );

    lldpi_dram_end lldpi_dram_end_inst (
        .link      (lldpi_link_if_inst),
        .i_reset_n (i_reset_n),
        .o_cfg     (o_cfg),
        .o_refresh (o_refresh)
    );

    lldpi_assertions lldpi_assertions_inst (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .cmd_clk     (lldpi_link_if_inst.cmd_clk),
        .cmd_clk_n   (lldpi_link_if_inst.cmd_clk_n),
        .cs_n        (lldpi_link_if_inst.cs_n),
        .we_n        (lldpi_link_if_inst.we_n),
        .ref_n       (lldpi_link_if_inst.ref_n),
        .addr_in     (lldpi_link_if_inst.addr_in),
        .wr_strobe   (lldpi_link_if_inst.wr_strobe),
        .wr_strobe_n (lldpi_link_if_inst.wr_strobe_n),
        .host_dq_oe  (lldpi_link_if_inst.host_dq_oe),
        .dev_dq_oe   (lldpi_link_if_inst.dev_dq_oe),
        .rd_strobe   (lldpi_link_if_inst.rd_strobe),
        .rd_strobe_n (lldpi_link_if_inst.rd_strobe_n),
        .rd_valid    (lldpi_link_if_inst.rd_valid)
    );

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
    end
    always #5 i_clk = ~i_clk;

    // verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one compare for every kind of result
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held from a falling edge until ready is seen
    task automatic req(input lldpi_cmd_e c, input logic [2:0] b, input logic [21:0] a,
                       input logic [71:0] d, input logic [1:0] m);
        int k;
        @(negedge i_clk);
        i_req_cmd = c;
        {i_req_bank, i_req_addr, i_req_wdata, i_req_wmask} = {b, a, d, m};
        i_req_valid = 1'b1;
        k = 0;
        while (o_req_ready !== 1'b1 && k < 100) begin
            @(negedge i_clk);
            k++;
        end
        chk("ready", 72'h0, 72'(k == 100));
        @(posedge i_clk);
        @(negedge i_clk);
        i_req_valid = 1'b0;
    endtask

    // read, bounded wait for the answer, compare
    task automatic rd_chk(input logic [2:0] b, input logic [21:0] a, input logic [71:0] e);
        req(LLDPI_READ, b, a, 72'h0, 2'h0);
        last_wait = 0;
        while (o_rd_valid !== 1'b1 && last_wait < 80) begin
            @(negedge i_clk);
            last_wait++;
        end
        chk("read data", e, o_rd_data);
    endtask

    // distinct test word per index
    function automatic logic [71:0] pat(input logic [7:0] k);
        return 72'h5a_a5c3_3c96_69f0_0f12 ^ {9{k}};
    endfunction

    // hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("BAD timeout expected done seen running");
            close_out();
        end
    end

    initial begin
        {i_reset_n, i_req_valid, i_req_bank, i_req_addr, i_req_wdata, i_req_wmask} = '0;
        i_req_cmd = LLDPI_READ;
        {num_errors, tests_run, cycles} = '0;
        repeat (10) @(negedge i_clk);
        i_reset_n = 1'b1;
        // every bank; expansion bits only on write
        for (int b = 0; b < 8; b++) begin
            req(LLDPI_WRITE, 3'(b), 22'h30_0000 | 22'(b * 5), pat(8'(b)), 2'h0);
        end
        for (int b = 0; b < 8; b++) begin
            rd_chk(3'(b), 22'(b * 5), pat(8'(b)));
        end
        $display("test banks done");
        // masked beats keep the stored half
        {w, v, u} = {pat(8'h20), pat(8'h21), pat(8'h22)};
        req(LLDPI_WRITE, 3'h1, 22'h00_0009, w, 2'h0);
        req(LLDPI_WRITE, 3'h1, 22'h00_0009, v, 2'h1);
        rd_chk(3'h1, 22'h00_0009, {v[71:36], w[35:0]});
        req(LLDPI_WRITE, 3'h1, 22'h00_0009, u, 2'h2);
        rd_chk(3'h1, 22'h00_0009, {v[71:36], u[35:0]});
        req(LLDPI_WRITE, 3'h1, 22'h00_0009, w, 2'h3);
        rd_chk(3'h1, 22'h00_0009, {v[71:36], u[35:0]});
        $display("test mask done");
        // refresh pulses once, stored data kept
        req(LLDPI_REFRESH, 3'h2, 22'h00_0000, 72'h0, 2'h0);
        n = 0;
        repeat (10) begin
            @(negedge i_clk);
            n += int'(o_refresh === 1'b1);
        end
        chk("refresh cycles", 72'h2, 72'(n));
        rd_chk(3'h1, 22'h00_0009, {v[71:36], u[35:0]});
        $display("test refresh done");
        // every latency code loaded and timed
        for (int l = 0; l < 8; l++) begin
            cfgv = 22'h05_a5a8 | 22'(l);
            req(LLDPI_CFG, 3'h0, cfgv, 72'h0, 2'h0);
            repeat (3) @(negedge i_clk);
            chk("config", 72'(cfgv), 72'(o_cfg));
            rd_chk(3'h1, 22'h00_0009, {v[71:36], u[35:0]});
            if (l == 0) begin
                lat0 = last_wait;
            end
            chk("latency", 72'(2 * l), 72'(last_wait - lat0));
        end
        $display("test latency done");
        close_out();
    end
endmodule
